// ---- src/edt_regs.vh ----
// Constants for the exception dispatch and trap frame unit.
// Assumes APB byte addressing with 32-bit data words.
// Notes on behaviour
// - Dispatch: kernel mode, frame, save, args, jump
// - Firmware-resolved exceptions never reach kernel
// - Each exception sorted into exactly one class
// - Invalid table entry raises translation fault
// - Protection mismatch raises access violation
// - Panic class never returns, signals crash
// - Return reloads state from trap frame
// - Return sets software interrupt requests
// - Service calls return by service-return only
// - Return may enter user startup code
// - Service calls accepted from either mode
// - Kernel stack stays 16-byte aligned
// - Frame length multiple of 32 bytes
// - Frame slots store full 64-bit values
// - Frame holds sp psw pc a0-a3 fp gp ra
// - User memory fault uses initial kernel stack
// - Set sp fp to frame, gp, restart
// - a0 store flag, a1 va, a2 mode, a3 psw
// - Other registers untouched by dispatch
`ifndef EDT_REGS_VH
`define EDT_REGS_VH

`define EDT_CLS_MEM 2'd0
`define EDT_CLS_SVC 2'd1
`define EDT_CLS_GEN 2'd2
`define EDT_CLS_PANIC 2'd3

`define EDT_FRAME_LENGTH 64'h0000_0000_0000_0060
`define EDT_FRAME_SLOTS 4'd10
`define EDT_STACK_ALIGN_MASK 64'hFFFF_FFFF_FFFF_FFE0

`define EDT_SLOT_SP 4'd0
`define EDT_SLOT_PSW 4'd1
`define EDT_SLOT_PC 4'd2
`define EDT_SLOT_A0 4'd3
`define EDT_SLOT_A1 4'd4
`define EDT_SLOT_A2 4'd5
`define EDT_SLOT_A3 4'd6
`define EDT_SLOT_FP 4'd7
`define EDT_SLOT_GP 4'd8
`define EDT_SLOT_RA 4'd9

`define EDT_PSW_MODE_BIT 0
`define EDT_PSW_RST 32'h0000_0000

`define EDT_ADDR_CTRL 12'h000
`define EDT_ADDR_STATUS 12'h004
`define EDT_ADDR_INITIAL_KERNEL_STACK_POINTER_LO 12'h008
`define EDT_ADDR_INITIAL_KERNEL_STACK_POINTER_HI 12'h00C
`define EDT_ADDR_KGP_LO 12'h010
`define EDT_ADDR_KGP_HI 12'h014
`define EDT_ADDR_ENTRY_LO 12'h020
`define EDT_ADDR_ENTRY_HI 12'h024
`define EDT_ADDR_SWIRQ 12'h018

`endif

// ---- src/edt_frame_mem.v ----
// Trap frame storage: sixteen 64-bit slots, registered read.
// Assumes a single clock and synchronous write enable.
`timescale 1ns/1ps
`default_nettype none
module edt_frame_mem
(
  input wire clk,
  input wire we,
  input wire [3:0] waddr,
  input wire [63:0] wdata,
  input wire [3:0] raddr,
  output reg [63:0] rdata
);
  reg [63:0] mem [0:15];

  always @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // edt_frame_mem
`default_nettype wire

// ---- src/edt_dispatch.v ----
// Exception dispatch, trap frame save and return restore.
// Assumes exception requests from a core pipeline and APB registers.
`timescale 1ns/1ps
`default_nettype none
`include "edt_regs.vh"
module edt_dispatch
(
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire exc_valid,
  input wire [3:0] exc_cause,
  input wire exc_firmware_done,
  input wire pte_l1_valid,
  input wire pte_l2_valid,
  input wire [3:0] pte_prot_mask,
  input wire [1:0] access_type,
  input wire is_store,
  input wire [63:0] fault_va,
  input wire [63:0] exc_pc,
  input wire [63:0] cur_sp,
  input wire [63:0] cur_fp,
  input wire [63:0] cur_gp,
  input wire [63:0] cur_ra,
  input wire [63:0] cur_a0,
  input wire [63:0] cur_a1,
  input wire [63:0] cur_a2,
  input wire [63:0] cur_a3,
  input wire rfe_req,
  input wire retsys_req,
  input wire [1:0] rfe_swirq,
  output wire busy,
  output reg done,
  output reg [1:0] exc_class,
  output reg restart_valid,
  output reg [63:0] restart_pc,
  output reg [63:0] new_sp,
  output reg [63:0] new_fp,
  output reg [63:0] new_gp,
  output reg [63:0] new_a0,
  output reg [63:0] new_a1,
  output reg [63:0] new_a2,
  output reg [63:0] new_a3,
  output reg [63:0] new_ra,
  output reg [31:0] processor_status_word,
  output reg [1:0] sw_irq_req,
  output reg panic_crash,
  output reg illegal_return
);
  localparam S_IDLE = 5'b00001;
  localparam S_SAVE = 5'b00010;
  localparam S_LOAD = 5'b00100;
  localparam S_REST = 5'b01000;
  localparam S_HALT = 5'b10000;

  // Cause codes from the core
  localparam [3:0] C_MEM = 4'h0;
  localparam [3:0] C_SVC = 4'h1;
  localparam [3:0] C_KSTK = 4'h8;
  localparam [3:0] C_FWX = 4'h9;

  reg [4:0] state_q;
  reg [3:0] slot_q;
  reg [63:0] tp_q;
  reg [31:0] prev_psw_q;
  reg last_svc_q;
  reg [63:0] initial_kernel_stack_pointer_q;
  reg [63:0] kgp_q;
  reg [63:0] entry_q [0:3];
  reg [63:0] va_q;
  reg store_q;
  reg [63:0] snap [0:15];
  reg [1:0] cls;
  reg mem_fault;
  reg [63:0] base;
  reg [63:0] wr_data;
  reg [31:0] rd_mux;
  integer i;
  integer j;
  wire [63:0] mem_rdata;
  wire mem_we;
  wire apb_wr;
  wire apb_rd;
  wire prot_ok;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & ~penable & ~pwrite;
  assign busy = (state_q != S_IDLE);
  assign prot_ok = pte_prot_mask[access_type];
  assign mem_we = (state_q == S_SAVE);

  // Classification and fault detection
  always @*
  begin
    mem_fault = (exc_cause == C_MEM) & (~pte_l1_valid | ~pte_l2_valid | ~prot_ok);
    if (exc_cause == C_KSTK || exc_cause == C_FWX)
    begin
      cls = `EDT_CLS_PANIC;
    end
    else if (mem_fault)
    begin
      cls = `EDT_CLS_MEM;
    end
    else if (exc_cause == C_SVC)
    begin
      cls = `EDT_CLS_SVC;
    end
    else
    begin
      cls = `EDT_CLS_GEN;
    end
    if (cls == `EDT_CLS_MEM && processor_status_word[`EDT_PSW_MODE_BIT])
    begin
      base = initial_kernel_stack_pointer_q;
    end
    else
    begin
      base = cur_sp;
    end
  end

  always @*
  begin
    wr_data = snap[slot_q];
  end

  edt_frame_mem u_mem
  (
    .clk(clk),
    .we(mem_we),
    .waddr(slot_q),
    .wdata(wr_data),
    .raddr(slot_q),
    .rdata(mem_rdata)
  );

  // Register read mux
  always @*
  begin
    case (paddr)
      `EDT_ADDR_STATUS: rd_mux = {24'h0000_00, panic_crash, illegal_return, exc_class, 4'h0};
      `EDT_ADDR_INITIAL_KERNEL_STACK_POINTER_LO: rd_mux = initial_kernel_stack_pointer_q[31:0];
      `EDT_ADDR_INITIAL_KERNEL_STACK_POINTER_HI: rd_mux = initial_kernel_stack_pointer_q[63:32];
      `EDT_ADDR_KGP_LO: rd_mux = kgp_q[31:0];
      `EDT_ADDR_KGP_HI: rd_mux = kgp_q[63:32];
      `EDT_ADDR_CTRL: rd_mux = processor_status_word;
      `EDT_ADDR_SWIRQ: rd_mux = {30'h0000_0000, sw_irq_req};
      default: rd_mux = (paddr[11:5] == 7'h01) ?
        (paddr[2] ? entry_q[paddr[4:3]][63:32] : entry_q[paddr[4:3]][31:0]) : 32'h0000_0000;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0000_0000;
      initial_kernel_stack_pointer_q <= 64'h0000_0000_0000_0000;
      kgp_q <= 64'h0000_0000_0000_0000;
      for (j = 0; j < 4; j = j + 1)
      begin
        entry_q[j] <= 64'h0000_0000_0000_0000;
      end
    end
    else
    begin
      if (apb_rd)
      begin
        prdata <= rd_mux;
      end
      if (apb_wr)
      begin
        case (paddr)
          `EDT_ADDR_INITIAL_KERNEL_STACK_POINTER_LO: initial_kernel_stack_pointer_q[31:0] <= {pwdata[31:4], 4'h0};
          `EDT_ADDR_INITIAL_KERNEL_STACK_POINTER_HI: initial_kernel_stack_pointer_q[63:32] <= pwdata;
          `EDT_ADDR_KGP_LO: kgp_q[31:0] <= pwdata;
          `EDT_ADDR_KGP_HI: kgp_q[63:32] <= pwdata;
          default:
          begin
            if (paddr[11:5] == 7'h01)
            begin
              if (paddr[2])
              begin
                entry_q[paddr[4:3]][63:32] <= pwdata;
              end
              else
              begin
                entry_q[paddr[4:3]][31:0] <= pwdata;
              end
            end
          end
        endcase
      end
    end
  end

  // Dispatch and return sequencer
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_IDLE;
      slot_q <= 4'h0;
      tp_q <= 64'h0000_0000_0000_0000;
      prev_psw_q <= `EDT_PSW_RST;
      last_svc_q <= 1'b0;
      va_q <= 64'h0000_0000_0000_0000;
      store_q <= 1'b0;
      done <= 1'b0;
      exc_class <= 2'd0;
      restart_valid <= 1'b0;
      restart_pc <= 64'h0000_0000_0000_0000;
      new_sp <= 64'h0000_0000_0000_0000;
      new_fp <= 64'h0000_0000_0000_0000;
      new_gp <= 64'h0000_0000_0000_0000;
      new_a0 <= 64'h0000_0000_0000_0000;
      new_a1 <= 64'h0000_0000_0000_0000;
      new_a2 <= 64'h0000_0000_0000_0000;
      new_a3 <= 64'h0000_0000_0000_0000;
      new_ra <= 64'h0000_0000_0000_0000;
      processor_status_word <= `EDT_PSW_RST;
      sw_irq_req <= 2'b00;
      panic_crash <= 1'b0;
      illegal_return <= 1'b0;
      for (i = 0; i < 16; i = i + 1)
      begin
        snap[i] <= 64'h0000_0000_0000_0000;
      end
    end
    else
    begin
      done <= 1'b0;
      restart_valid <= 1'b0;
      illegal_return <= 1'b0;
      if (apb_wr && (paddr == `EDT_ADDR_CTRL))
        processor_status_word <= pwdata;
      case (state_q)
        S_IDLE:
        begin
          if (exc_valid && !exc_firmware_done)
          begin
            exc_class <= cls;
            prev_psw_q <= processor_status_word;
            va_q <= fault_va;
            store_q <= is_store;
            last_svc_q <= (cls == `EDT_CLS_SVC);
            processor_status_word[`EDT_PSW_MODE_BIT] <= 1'b0;
            // Frame below base, 32-byte aligned, keeps 16-byte alignment
            tp_q <= (base - `EDT_FRAME_LENGTH) & `EDT_STACK_ALIGN_MASK;
            snap[0] <= cur_sp;
            snap[1] <= {32'h0000_0000, processor_status_word};
            snap[2] <= exc_pc;
            snap[3] <= cur_a0;
            snap[4] <= cur_a1;
            snap[5] <= cur_a2;
            snap[6] <= cur_a3;
            snap[7] <= cur_fp;
            snap[8] <= cur_gp;
            snap[9] <= cur_ra;
            slot_q <= 4'h0;
            if (cls == `EDT_CLS_PANIC)
            begin
              state_q <= S_HALT;
              panic_crash <= 1'b1;
            end
            else
            begin
              state_q <= S_SAVE;
            end
          end
          else if (rfe_req || retsys_req)
          begin
            if (rfe_req && last_svc_q)
            begin
              illegal_return <= 1'b1;
            end
            else
            begin
              slot_q <= 4'h0;
              sw_irq_req <= rfe_req ? rfe_swirq : sw_irq_req;
              state_q <= S_REST;
            end
          end
        end
        S_SAVE:
        begin
          if (slot_q == `EDT_FRAME_SLOTS - 4'd1)
          begin
            state_q <= S_LOAD;
          end
          else
          begin
            slot_q <= slot_q + 4'd1;
          end
        end
        S_LOAD:
        begin
          new_sp <= tp_q;
          new_fp <= tp_q;
          new_gp <= kgp_q;
          new_ra <= snap[9];
          new_a0 <= snap[3];
          new_a1 <= snap[4];
          new_a2 <= snap[5];
          new_a3 <= snap[6];
          if (exc_class == `EDT_CLS_MEM)
          begin
            new_a0 <= {63'h0, store_q};
            new_a1 <= va_q;
            new_a2 <= {63'h0, prev_psw_q[`EDT_PSW_MODE_BIT]};
            new_a3 <= {32'h0000_0000, prev_psw_q};
          end
          restart_pc <= entry_q[exc_class];
          restart_valid <= 1'b1;
          done <= 1'b1;
          state_q <= S_IDLE;
        end
        S_REST:
        begin
          // Read data lags address by one cycle
          if (slot_q != `EDT_FRAME_SLOTS)
          begin
            slot_q <= slot_q + 4'd1;
          end
          if (slot_q != 4'h0)
          begin
            case (slot_q - 4'd1)
              `EDT_SLOT_SP: new_sp <= mem_rdata;
              `EDT_SLOT_PSW: processor_status_word <= mem_rdata[31:0];
              `EDT_SLOT_PC: restart_pc <= mem_rdata;
              `EDT_SLOT_A0: new_a0 <= mem_rdata;
              `EDT_SLOT_A1: new_a1 <= mem_rdata;
              `EDT_SLOT_A2: new_a2 <= mem_rdata;
              `EDT_SLOT_A3: new_a3 <= mem_rdata;
              `EDT_SLOT_FP: new_fp <= mem_rdata;
              `EDT_SLOT_GP: new_gp <= mem_rdata;
              default: new_ra <= mem_rdata;
            endcase
          end
          if (slot_q == `EDT_FRAME_SLOTS)
          begin
            restart_valid <= 1'b1;
            done <= 1'b1;
            last_svc_q <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        S_HALT:
        begin
          panic_crash <= 1'b1;
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // edt_dispatch
`default_nettype wire

// ---- tb/edt_monitor.sv ----
// Bound checker for the exception dispatch unit.
// Sees only top-level ports; one clock, async low reset.
`timescale 1ns/1ps
`default_nettype none
module edt_monitor
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic busy,
  input wire logic exc_valid,
  input wire logic exc_firmware_done,
  input wire logic [3:0] exc_cause,
  input wire logic pte_l1_valid,
  input wire logic is_store,
  input wire logic rfe_req,
  input wire logic retsys_req,
  input wire logic done,
  input wire logic restart_valid,
  input wire logic [1:0] exc_class,
  input wire logic [63:0] new_sp,
  input wire logic [63:0] new_fp,
  input wire logic [63:0] new_a0,
  input wire logic panic_crash
);
  logic acc;
  logic mem;
  assign acc = exc_valid && !exc_firmware_done && !busy && !panic_crash && !rfe_req && !retsys_req;
  assign mem = acc && exc_cause == 4'h0 && !pte_l1_valid;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  done_a:
    assert property (acc && exc_cause[3:1] != 3'h4 |-> ##12 (done && restart_valid))
    else $error("dispatch late");
  sp_align_a:
    assert property (acc && exc_cause[3:1] != 3'h4 |-> ##12 (new_sp[4:0] == 5'h00))
    else $error("frame unaligned");
  sp_fp_a:
    assert property (acc && exc_cause[3:1] != 3'h4 |-> ##12 (new_fp == new_sp))
    else $error("fp not frame");
  fw_skip_a:
    assert property (!busy && exc_valid && exc_firmware_done && !rfe_req && !retsys_req |=> !busy)
    else $error("firmware case dispatched");
  tnv_class_a:
    assert property (mem |=> exc_class == 2'h0)
    else $error("fault class wrong");
  svc_class_a:
    assert property (acc && exc_cause == 4'h1 |=> exc_class == 2'h1)
    else $error("service class wrong");
  store_flag_a:
    assert property (mem |-> ##12 (new_a0 == {63'h0, $past(is_store, 12)}))
    else $error("store flag wrong");
  panic_stop_a:
    assert property (acc && exc_cause[3:1] == 3'h4 |=> (panic_crash && !done) [*4])
    else $error("panic not held");
endmodule // edt_monitor

bind edt_dispatch edt_monitor mon (.clk, .rst_n, .busy, .exc_valid, .exc_firmware_done,
  .exc_cause, .pte_l1_valid, .is_store, .rfe_req, .retsys_req, .done, .restart_valid,
  .exc_class, .new_sp, .new_fp, .new_a0, .panic_crash);
`default_nettype wire

// ---- tb/exception_dispatch_trap_frame_tb.sv ----
// Self-checking bench for the exception dispatch unit.
// Drives APB and the core side directly; edt_monitor is bound in.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module exception_dispatch_trap_frame_tb;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic exc_valid = 1'b0, exc_firmware_done = 1'b0, pte_l1_valid = 1'b1, pte_l2_valid = 1'b1;
  logic is_store = 1'b0, rfe_req = 1'b0, retsys_req = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] exc_cause = 4'h0, pte_prot_mask = 4'hF;
  logic [1:0] access_type = 2'h0, rfe_swirq = 2'h0;
  logic [63:0] cv [10];
  logic [63:0] sv [10];
  logic [31:0] rd, prdata, processor_status_word;
  logic pready, pslverr, busy, done, restart_valid, panic_crash, illegal_return, seen, ill;
  logic [1:0] exc_class, sw_irq_req;
  logic [63:0] restart_pc, new_sp, new_fp, new_gp, new_a0, new_a1, new_a2, new_a3, new_ra;
  int miscompares = 0;
  int n_compared = 0;

  edt_dispatch uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .exc_valid, .exc_cause, .exc_firmware_done, .pte_l1_valid, .pte_l2_valid,
    .pte_prot_mask, .access_type, .is_store, .fault_va(cv[9]), .exc_pc(cv[0]), .cur_sp(cv[1]),
    .cur_fp(cv[2]), .cur_gp(cv[3]), .cur_ra(cv[4]), .cur_a0(cv[5]), .cur_a1(cv[6]),
    .cur_a2(cv[7]), .cur_a3(cv[8]), .rfe_req, .retsys_req, .rfe_swirq, .busy, .done, .exc_class,
    .restart_valid, .restart_pc, .new_sp, .new_fp, .new_gp, .new_a0, .new_a1, .new_a2, .new_a3,
    .new_ra, .processor_status_word, .sw_irq_req, .panic_crash, .illegal_return);

  always #4 clk = ~clk;

  function automatic logic [63:0] ent(input logic [1:0] c);
    return 64'h0000_00AB_0000_1000 + {56'h0, c, 6'h00};
  endfunction

  function automatic logic [63:0] frm(input logic [63:0] b);
    return (b - 64'h0000_0000_0000_0060) & 64'hFFFF_FFFF_FFFF_FFE0;
  endfunction

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic w64(input logic [11:0] a, input logic [63:0] v);
    apb(a, 1'b1, v[31:0]);
    apb(a + 12'h004, 1'b1, v[63:32]);
  endtask

  // Kind 0 exception, 1 return, 2 service return
  task automatic go(input logic [1:0] k, input logic [3:0] c);
    @(posedge clk);
    exc_cause <= c;
    exc_valid <= (k == 2'h0);
    rfe_req <= (k == 2'h1);
    retsys_req <= (k == 2'h2);
    @(posedge clk);
    exc_valid <= 1'b0;
    rfe_req <= 1'b0;
    retsys_req <= 1'b0;
    ill = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      @(negedge clk);
      if (illegal_return === 1'b1)
        ill = 1'b1;
      seen = (done === 1'b1);
      if (seen)
        break;
    end
    @(posedge clk);
  endtask

  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    for (int i = 0; i < 10; i++)
      cv[i] = 64'h8000_0000_0000_0107 + 64'h0000_0010_0000_1111 * i;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(12'h000, 1'b0, 32'h0000_0000);
    `CHK("psw", 32'h0000_0000, rd)
    `CHK("slverr", 1'h0, pslverr)
    apb(12'h0FC, 1'b0, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, rd)
    w64(12'h008, 64'h0000_0000_0000_4127);
    apb(12'h008, 1'b0, 32'h0000_0000);
    `CHK("initial_kernel_stack_pointer", 32'h0000_4120, rd)
    w64(12'h010, 64'h0000_0001_5555_0000);
    for (int c = 0; c < 4; c++)
      w64(12'h020 + 12'(8 * c), ent(c[1:0]));
    apb(12'h030, 1'b0, 32'h0000_0000);
    `CHK("entry", 32'h0000_1080, rd)
    $display("registers ended");
    pte_l1_valid <= 1'b0;
    is_store <= 1'b1;
    go(2'h0, 4'h0);
    `CHK("done", 1'h1, seen)
    `CHK("class", 2'h0, exc_class)
    `CHK("target", ent(2'h0), restart_pc)
    `CHK("sp", frm(cv[1]), new_sp)
    `CHK("fp", frm(cv[1]), new_fp)
    `CHK("gp", 64'h0000_0001_5555_0000, new_gp)
    `CHK("a0", 64'h1, new_a0)
    `CHK("a1", cv[9], new_a1)
    `CHK("a2", 64'h0, new_a2)
    `CHK("a3", 64'h0, new_a3)
    `CHK("ra", cv[4], new_ra)
    pte_l1_valid <= 1'b1;
    is_store <= 1'b0;
    pte_prot_mask <= 4'hB;
    access_type <= 2'h2;
    go(2'h0, 4'h0);
    `CHK("class", 2'h0, exc_class)
    `CHK("a0", 64'h0, new_a0)
    pte_prot_mask <= 4'hF;
    $display("memory fault ended");
    for (int c = 0; c < 16; c++)
    begin
      if (c == 8 || c == 9)
        continue;
      go(2'h0, c[3:0]);
      `CHK("class", (c == 1) ? 2'h1 : 2'h2, exc_class)
      `CHK("target", ent((c == 1) ? 2'h1 : 2'h2), restart_pc)
    end
    $display("classes ended");
    sv = cv;
    cv[0] <= 64'h0;
    cv[1] <= 64'h0;
    rfe_swirq <= 2'h2;
    go(2'h1, 4'h0);
    `CHK("done", 1'h1, seen)
    `CHK("sp", sv[1], new_sp)
    `CHK("pc", sv[0], restart_pc)
    `CHK("swirq", 2'h2, sw_irq_req)
    `CHK("psw", 32'h0, processor_status_word)
    go(2'h0, 4'h1);
    go(2'h1, 4'h0);
    `CHK("illegal", 1'h1, ill)
    go(2'h2, 4'h0);
    `CHK("retsys", 1'h1, seen)
    exc_firmware_done <= 1'b1;
    go(2'h0, 4'h2);
    `CHK("firmware", 1'h0, seen)
    exc_firmware_done <= 1'b0;
    $display("returns ended");
    cv <= sv;
    apb(12'h000, 1'b1, 32'h0000_0001);
    apb(12'h000, 1'b0, 32'h0000_0000);
    `CHK("psw user", 32'h0000_0001, rd)
    pte_l2_valid <= 1'b0;
    go(2'h0, 4'h0);
    `CHK("class", 2'h0, exc_class)
    `CHK("sp", 64'h0000_0000_0000_40C0, new_sp)
    `CHK("psw", 32'h0000_0000, processor_status_word)
    `CHK("a2", 64'h1, new_a2)
    `CHK("a3", 64'h1, new_a3)
    pte_l2_valid <= 1'b1;
    go(2'h1, 4'h0);
    `CHK("pc", cv[0], restart_pc)
    `CHK("psw", 32'h0000_0001, processor_status_word)
    `CHK("gp", cv[3], new_gp)
    `CHK("a3", cv[8], new_a3)
    $display("user mode ended");
    for (int c = 8; c < 10; c++)
    begin
      go(2'h0, c[3:0]);
      `CHK("panic", 1'h1, panic_crash)
      go(2'h0, 4'h0);
      `CHK("halt", 1'h0, seen)
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
    end
    $display("panic ended");
    final_report;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    final_report;
  end
endmodule // exception_dispatch_trap_frame_tb
`default_nettype wire
